// [rtl/tone_cfg_consts.svh]
// register offsets, field positions, reset values and scaling constants of the tone configuration block
`ifndef TONE_CFG_CONSTS_SVH
`define TONE_CFG_CONSTS_SVH
`define OFS_CH1_TONE2_CTRL_A 4'h7
`define OFS_CH1_TONE2_CTRL_B 4'h8
`define OFS_CH1_TONE1_LEVEL_FREQ_HI 4'h9
`define OFS_CH1_TONE1_FREQ_LO 4'ha
`define OFS_RINGING_SELECT_CREST_CTRL 4'hb
`define OFS_CH2_TONE1_CTRL_A 4'hc
`define OFS_CH2_TONE1_CTRL_B 4'hd
`define OFS_TONE_STATUS 4'he
`define REG_RESET 8'h00
`define LEVEL_MSB 7
`define LEVEL_LSB 1
`define FREQ_HI_BIT 0
`define RING_CH2_BIT 7
`define RING_CH1_BIT 3
`define TRAP_CH2_MSB 6
`define TRAP_CH2_LSB 4
`define TRAP_CH1_MSB 2
`define TRAP_CH1_LSB 0
`define RING_FREQ_MSB 5
`define VOICE_STEP_HZ 10
`define RING_STEP_HZ 1
`define VOICE_CODE_MIN 9'h01e
`define VOICE_CODE_MAX 9'h154
`define RING_CODE_MIN 6'h0f
`define RING_CODE_MAX 6'h32
`endif

// [rtl/tone_cfg_pkg.sv]
// types shared by the tone configuration block
package tone_cfg_pkg;
   typedef struct packed {
      logic enable;
      logic ring_mode;
      logic [8:0] freq_code;
      logic [6:0] level_code;
      logic [2:0] trapezoid_sel;
      logic freq_in_band;
   } gen_cfg_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage : tone_cfg_pkg

// [rtl/tone_voice_decode.sv]
// decodes a voice-band tone frequency code and its band check
`timescale 1ns/1ps
`include "tone_cfg_consts.svh"
module tone_voice_decode
   import tone_cfg_pkg::*;
(
   // register fields
   input wire logic freq_hi,
   input wire logic [7:0] freq_lo,
   // decoded code
   output logic [8:0] freq_code,
   output logic in_band
);
   always_comb begin
      freq_code = {freq_hi, freq_lo};
      in_band = (freq_code >= `VOICE_CODE_MIN) && (freq_code <= `VOICE_CODE_MAX);
   end
endmodule : tone_voice_decode

// [rtl/tone_gen1_decode.sv]
// decodes a generator-1 register pair into frequency, mode, level and waveform
`timescale 1ns/1ps
`include "tone_cfg_consts.svh"
module tone_gen1_decode
   import tone_cfg_pkg::*;
(
   // register fields
   input wire logic [7:0] level_freq_hi,
   input wire logic [7:0] freq_lo,
   input wire logic ring_sel,
   input wire logic [2:0] trap_sel,
   // decoded configuration
   output gen_cfg_t cfg
);
   logic [8:0] voice_code;
   logic voice_ok;
   tone_voice_decode u_voice (
      .freq_hi(level_freq_hi[`FREQ_HI_BIT]),
      .freq_lo(freq_lo),
      .freq_code(voice_code),
      .in_band(voice_ok)
   );
   always_comb begin
      cfg.level_code = level_freq_hi[`LEVEL_MSB:`LEVEL_LSB];
      cfg.enable = (cfg.level_code != 7'h00);
      cfg.ring_mode = ring_sel;
      if (ring_sel) begin
         // upper code bits are ignored in ringing mode; code is hertz directly
         cfg.freq_code = {3'h0, freq_lo[`RING_FREQ_MSB:0]};
         cfg.freq_in_band = (freq_lo[`RING_FREQ_MSB:0] >= `RING_CODE_MIN) &&
            (freq_lo[`RING_FREQ_MSB:0] <= `RING_CODE_MAX);
         cfg.trapezoid_sel = trap_sel;
      end else begin
         cfg.freq_code = voice_code;
         cfg.freq_in_band = voice_ok;
         // waveform field only applies while ringing
         cfg.trapezoid_sel = 3'h0;
      end
   end
endmodule : tone_gen1_decode

// [rtl/tone_gen_freq_level_config.sv]
// register bank and decoded tone generator settings for both channels
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "tone_cfg_consts.svh"
module tone_gen_freq_level_config
   import tone_cfg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // decoded generator settings
   output gen_cfg_t ch1_gen1_cfg,
   output gen_cfg_t ch2_gen1_cfg,
   output logic [8:0] ch1_gen2_freq_code,
   output logic ch1_gen2_in_band
);
   typedef struct packed {
      logic [7:0] ch1_tone2_ctrl_a;
      logic [7:0] ch1_tone2_ctrl_b;
      logic [7:0] ch1_tone1_level_freq_hi;
      logic [7:0] ch1_tone1_freq_lo;
      logic [7:0] ringing_select_crest_ctrl;
      logic [7:0] ch2_tone1_ctrl_a;
      logic [7:0] ch2_tone1_ctrl_b;
      logic [7:0] rdata;
      gen_cfg_t ch1_gen1;
      gen_cfg_t ch2_gen1;
      logic [8:0] gen2_code;
      logic gen2_ok;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   gen_cfg_t ch1_dec;
   gen_cfg_t ch2_dec;
   logic [8:0] gen2_dec;
   logic gen2_ok_dec;
   reg_req_t req;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   tone_voice_decode u_gen2 (
      .freq_hi(st_r.ch1_tone2_ctrl_a[`FREQ_HI_BIT]),
      .freq_lo(st_r.ch1_tone2_ctrl_b),
      .freq_code(gen2_dec),
      .in_band(gen2_ok_dec)
   );

   tone_gen1_decode u_ch1 (
      .level_freq_hi(st_r.ch1_tone1_level_freq_hi),
      .freq_lo(st_r.ch1_tone1_freq_lo),
      .ring_sel(st_r.ringing_select_crest_ctrl[`RING_CH1_BIT]),
      .trap_sel(st_r.ringing_select_crest_ctrl[`TRAP_CH1_MSB:`TRAP_CH1_LSB]),
      .cfg(ch1_dec)
   );

   tone_gen1_decode u_ch2 (
      .level_freq_hi(st_r.ch2_tone1_ctrl_a),
      .freq_lo(st_r.ch2_tone1_ctrl_b),
      .ring_sel(st_r.ringing_select_crest_ctrl[`RING_CH2_BIT]),
      .trap_sel(st_r.ringing_select_crest_ctrl[`TRAP_CH2_MSB:`TRAP_CH2_LSB]),
      .cfg(ch2_dec)
   );

   always_comb begin
      st_nxt = st_r;
      if (req.wr) begin
         unique case (req.addr)
            `OFS_CH1_TONE2_CTRL_A: st_nxt.ch1_tone2_ctrl_a = req.wdata;
            `OFS_CH1_TONE2_CTRL_B: st_nxt.ch1_tone2_ctrl_b = req.wdata;
            `OFS_CH1_TONE1_LEVEL_FREQ_HI: st_nxt.ch1_tone1_level_freq_hi = req.wdata;
            `OFS_CH1_TONE1_FREQ_LO: st_nxt.ch1_tone1_freq_lo = req.wdata;
            `OFS_RINGING_SELECT_CREST_CTRL: st_nxt.ringing_select_crest_ctrl = req.wdata;
            `OFS_CH2_TONE1_CTRL_A: st_nxt.ch2_tone1_ctrl_a = req.wdata;
            `OFS_CH2_TONE1_CTRL_B: st_nxt.ch2_tone1_ctrl_b = req.wdata;
            default: ;
         endcase
      end
      st_nxt.rdata = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            `OFS_CH1_TONE2_CTRL_A: st_nxt.rdata = st_r.ch1_tone2_ctrl_a;
            `OFS_CH1_TONE2_CTRL_B: st_nxt.rdata = st_r.ch1_tone2_ctrl_b;
            `OFS_CH1_TONE1_LEVEL_FREQ_HI: st_nxt.rdata = st_r.ch1_tone1_level_freq_hi;
            `OFS_CH1_TONE1_FREQ_LO: st_nxt.rdata = st_r.ch1_tone1_freq_lo;
            `OFS_RINGING_SELECT_CREST_CTRL: st_nxt.rdata = st_r.ringing_select_crest_ctrl;
            `OFS_CH2_TONE1_CTRL_A: st_nxt.rdata = st_r.ch2_tone1_ctrl_a;
            `OFS_CH2_TONE1_CTRL_B: st_nxt.rdata = st_r.ch2_tone1_ctrl_b;
            // live band checks, so software can see an unguaranteed setting
            `OFS_TONE_STATUS: st_nxt.rdata = {4'h0, st_r.ch2_gen1.enable, st_r.ch1_gen1.enable,
               st_r.ch1_gen1.freq_in_band, st_r.gen2_ok};
            default: st_nxt.rdata = 8'h00;
         endcase
      end
      // decoded outputs lag the register by one cycle so that every output is a flop
      st_nxt.ch1_gen1 = ch1_dec;
      st_nxt.ch2_gen1 = ch2_dec;
      st_nxt.gen2_code = gen2_dec;
      st_nxt.gen2_ok = gen2_ok_dec;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign ch1_gen1_cfg = st_r.ch1_gen1;
   assign ch2_gen1_cfg = st_r.ch2_gen1;
   assign ch1_gen2_freq_code = st_r.gen2_code;
   assign ch1_gen2_in_band = st_r.gen2_ok;

   chk_gen2_code_join: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 ch1_gen2_freq_code == {$past(st_r.ch1_tone2_ctrl_a[0]), $past(st_r.ch1_tone2_ctrl_b)})
      else $error("gen2 code not built from ctrl registers");
   chk_level_field: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 ch1_gen1_cfg.level_code == $past(st_r.ch1_tone1_level_freq_hi[7:1]))
      else $error("level field wrong");
   chk_level_off: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 ch1_gen1_cfg.enable == ($past(st_r.ch1_tone1_level_freq_hi[7:1]) != 7'h00))
      else $error("enable does not follow level code");
   chk_level_range: assert property (@(posedge sys_clk) disable iff (!nrst)
      ch1_gen1_cfg.enable |-> ch1_gen1_cfg.level_code >= 7'h01)
      else $error("enabled with zero level");
   chk_voice_freq: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 !$past(st_r.ringing_select_crest_ctrl[3]) |->
      ch1_gen1_cfg.freq_code == {$past(st_r.ch1_tone1_level_freq_hi[0]), $past(st_r.ch1_tone1_freq_lo)})
      else $error("voice frequency code wrong");
   chk_ring_freq: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 $past(st_r.ringing_select_crest_ctrl[3]) |->
      ch1_gen1_cfg.freq_code == {3'h0, $past(st_r.ch1_tone1_freq_lo[5:0])})
      else $error("ringing frequency code wrong");
   chk_ring_band: assert property (@(posedge sys_clk) disable iff (!nrst)
      ch1_gen1_cfg.ring_mode && ch1_gen1_cfg.freq_in_band |->
      ch1_gen1_cfg.freq_code >= 9'h00f && ch1_gen1_cfg.freq_code <= 9'h032)
      else $error("ringing band check wrong");
   chk_ch2_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 ch2_gen1_cfg.ring_mode == $past(st_r.ringing_select_crest_ctrl[7]))
      else $error("ch2 mode not from bit 7");
   chk_trap_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ch1_gen1_cfg.ring_mode |-> ch1_gen1_cfg.trapezoid_sel == 3'h0)
      else $error("trapezoid active outside ringing");
   chk_readback: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_wr && reg_addr == 4'h9 ##1 reg_rd && reg_addr == 4'h9 && !$past(reg_rd) |->
      ##1 reg_rdata == $past(reg_wdata, 2))
      else $error("readback differs from write");
   chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read cycle");
   chk_gen2_band: assert property (@(posedge sys_clk) disable iff (!nrst)
      ch1_gen2_in_band == (ch1_gen2_freq_code >= 9'h01e && ch1_gen2_freq_code <= 9'h154))
      else $error("gen2 band flag wrong");
   chk_ch2_level: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 ch2_gen1_cfg.level_code == $past(st_r.ch2_tone1_ctrl_a[7:1]))
      else $error("ch2 level field wrong");
   chk_ch2_trap_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ch2_gen1_cfg.ring_mode |-> ch2_gen1_cfg.trapezoid_sel == 3'h0)
      else $error("ch2 trapezoid active outside ringing");
endmodule : tone_gen_freq_level_config

// [verification/testbench.sv]
// self-checking bench for the tone generator configuration registers
`timescale 1ns/1ps
module testbench
   import tone_cfg_pkg::*;
;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   gen_cfg_t ch1_gen1_cfg;
   gen_cfg_t ch2_gen1_cfg;
   logic [8:0] ch1_gen2_freq_code;
   logic ch1_gen2_in_band;
   int fails = 0;
   int checks = 0;
   // {ctrl_a, ctrl_b, in_band, code}: both band edges and one step outside each
   logic [25:0] gen2_tab [4] = '{{8'h01, 8'h54, 10'h354}, {8'h01, 8'h55, 10'h155},
                                 {8'h00, 8'h1e, 10'h21e}, {8'h00, 8'h1d, 10'h01d}};
   // ringing byte with junk in bits 7..6, and expected {in_band, code}
   logic [7:0] ring_lo [4] = '{8'h8f, 8'h72, 8'h4e, 8'hf3};
   logic [6:0] ring_exp [4] = '{7'h4f, 7'h72, 7'h0e, 7'h33};

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   tone_gen_freq_level_config dut (
      .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch1_gen1_cfg(ch1_gen1_cfg),
      .ch2_gen1_cfg(ch2_gen1_cfg), .ch1_gen2_freq_code(ch1_gen2_freq_code),
      .ch1_gen2_in_band(ch1_gen2_in_band)
   );

   function automatic gen_cfg_t mk(logic en, logic ring, logic [8:0] f, logic [6:0] lv, logic [2:0] tr,
                                   logic ib);
      return '{en, ring, f, lv, tr, ib};
   endfunction : mk

   task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(21'(reg_rdata), 21'(e));
   endtask : rd

   // decoded outputs follow the register one edge later
   task automatic settle;
      @(posedge sys_clk);
      #1;
   endtask : settle

   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      end_of_test;
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int a = 7; a <= 13; a++) begin
         rd(4'(a), 8'h00);
      end
      chk(ch1_gen1_cfg, mk(0, 0, 9'h000, 7'h00, 3'h0, 0));
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         wr(4'h7, gen2_tab[i][25:18]);
         wr(4'h8, gen2_tab[i][17:10]);
         settle;
         chk(21'({ch1_gen2_in_band, ch1_gen2_freq_code}), 21'(gen2_tab[i][9:0]));
      end
      $display("test generator 2 frequency done");
      // write then read with no gap, so the read-after-write path is exercised
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= 4'h9;
      reg_wdata <= 8'h80;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(21'(reg_rdata), 21'(8'h80));
      chk(ch1_gen1_cfg, mk(1, 0, 9'h000, 7'h40, 3'h0, 0));
      wr(4'ha, 8'h2c);
      wr(4'h9, 8'h01);
      settle;
      chk(ch1_gen1_cfg, mk(0, 0, 9'h12c, 7'h00, 3'h0, 1));
      wr(4'h9, 8'hff);
      wr(4'hb, 8'h07);
      settle;
      chk(ch1_gen1_cfg, mk(1, 0, 9'h12c, 7'h7f, 3'h0, 1));
      $display("test level and voice frequency done");
      for (int i = 0; i < 8; i++) begin
         wr(4'hb, 8'h08 | 8'(i));
         wr(4'ha, ring_lo[i % 4]);
         settle;
         chk(ch1_gen1_cfg, mk(1, 1, {3'h0, ring_exp[i % 4][5:0]}, 7'h7f, i[2:0], ring_exp[i % 4][6]));
      end
      $display("test ringing mode done");
      wr(4'hc, 8'h01);
      wr(4'hd, 8'h2c);
      settle;
      chk(ch2_gen1_cfg, mk(0, 0, 9'h12c, 7'h00, 3'h0, 1));
      wr(4'hb, 8'hf0);
      settle;
      chk(ch2_gen1_cfg, mk(0, 1, 9'h02c, 7'h00, 3'h7, 1));
      chk(ch1_gen1_cfg, mk(1, 0, 9'h1f3, 7'h7f, 3'h0, 0));
      $display("test channel 2 ringing done");
      wr(4'hf, 8'haa);
      wr(4'he, 8'hff);
      rd(4'h0, 8'h00);
      rd(4'hf, 8'h00);
      rd(4'h8, 8'h1d);
      rd(4'hb, 8'hf0);
      rd(4'he, 8'h04);
      $display("test unmapped access done");
      @(posedge sys_clk);
      nrst <= 1'b0;
      settle;
      chk(ch1_gen1_cfg, mk(0, 0, 9'h000, 7'h00, 3'h0, 0));
      chk(ch2_gen1_cfg, mk(0, 0, 9'h000, 7'h00, 3'h0, 0));
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(4'hb, 8'h00);
      rd(4'h9, 8'h00);
      $display("test mid-run reset done");
      end_of_test;
   end
endmodule : testbench
